// ==== common/cbdp_cfg.svh ====
// constants for the cpu bus data and parity pin block
// assumes it is included by bare name wherever the numbers are needed
`ifndef CBDP_CFG_SVH
`define CBDP_CFG_SVH

// data path: 64 data lines in eight byte lanes, one parity bit each
`define CBDP_DATA_W 64
`define CBDP_LANES 8
`define CBDP_LANE_W 8

// inquire hit answer follows the sampled strobe by two clocks
`define CBDP_INQ_HIT_DLY 2

// read data buffer in the cpu end
`define CBDP_BUF_DEPTH 2

// idle (negated) level of the active-low bus lines
`define CBDP_NEG 1'b1

`endif

// ==== common/cbdp_pkg.sv ====
// types and the shared parity function of the cpu bus pin block
// assumes cbdp_cfg.svh sits on the include path
`include "cbdp_cfg.svh"

package cbdp_pkg;

    typedef logic [`CBDP_DATA_W-1:0] cbdp_data_t;
    typedef logic [`CBDP_LANES-1:0] cbdp_par_t;

    // bus states of the cpu end; only the non-pipelined data state is used
    typedef enum logic [1:0] {
        CBDP_IDLE,
        CBDP_ADDR,
        CBDP_DATA
    } cbdp_state_t;

    // one bit per lane makes ones of lane plus bit even
    function automatic cbdp_par_t cbdp_even_par(input cbdp_data_t d);
        cbdp_par_t p;
        p = '0;
        for (int i = 0; i < `CBDP_LANES; i++) begin
            p[i] = ^d[i*`CBDP_LANE_W +: `CBDP_LANE_W];
        end
        return p;
    endfunction

endpackage

// ==== common/cbdp_if.sv ====
// pins between the cpu end and the system end of the bus
// assumes one shared clock; two-way pins are resolved here from enables
`timescale 1ns/10ps
`include "cbdp_cfg.svh"

interface cbdp_if
    import cbdp_pkg::*;
();
    // cycle definition, driven by the cpu end
    logic address_strobe_out_n;
    logic bus_write;
    logic data_code;
    logic dual_primary_n_o;
    logic dual_primary_n_oe;
    logic dual_primary_n;
    // data and parity lines, both ends may drive
    cbdp_data_t data_cpu_o;
    logic data_cpu_oe;
    cbdp_par_t par_cpu_o;
    cbdp_data_t data_sys_o;
    logic data_sys_oe;
    cbdp_par_t par_sys_o;
    cbdp_data_t data_lines;
    cbdp_par_t byte_parity_lines;
    // handshakes and straps driven by the system end
    logic burst_ready_ack_n;
    logic cpu_reset;
    logic processor_role_strap;
    logic inquire_address_strobe_n;
    logic ext_write_buffer_empty_n;
    // open-drain dual enable shared with interrupt data bit 0
    logic dual_enable_line_n_o;
    logic dual_enable_line_n_oe;
    logic dual_enable_line_n;
    logic inquire_hit_n;

    // wire resolution; an undriven line reads as its pull level
    assign data_lines = data_cpu_oe ? data_cpu_o :
                        (data_sys_oe ? data_sys_o : '0);
    assign byte_parity_lines = data_cpu_oe ? par_cpu_o :
                               (data_sys_oe ? par_sys_o : '0);
    assign dual_enable_line_n = dual_enable_line_n_oe ?
                                dual_enable_line_n_o : `CBDP_NEG;
    assign dual_primary_n = dual_primary_n_oe ?
                            dual_primary_n_o : `CBDP_NEG;

    modport cpu_mp (
        output address_strobe_out_n, bus_write, data_code,
        output dual_primary_n_o, dual_primary_n_oe,
        output data_cpu_o, data_cpu_oe, par_cpu_o,
        output dual_enable_line_n_o, dual_enable_line_n_oe, inquire_hit_n,
        input data_lines, byte_parity_lines, burst_ready_ack_n, cpu_reset,
        input processor_role_strap, inquire_address_strobe_n,
        input ext_write_buffer_empty_n
    );

    modport sys_mp (
        input address_strobe_out_n, bus_write, data_code, dual_primary_n,
        input data_lines, byte_parity_lines, dual_enable_line_n,
        input inquire_hit_n,
        output data_sys_o, data_sys_oe, par_sys_o,
        output burst_ready_ack_n, cpu_reset, processor_role_strap,
        output inquire_address_strobe_n, ext_write_buffer_empty_n
    );
endinterface // cbdp_if

// ==== hw/cbdp_cpu_end.sv ====
// cpu end of the bus: cycle strobes, data and parity lanes, dual enable,
// inquire hit and write throttle, plus a two-entry read data buffer
// assumes the system end shares sys_clk_i and drives the bus on that clock
`timescale 1ns/10ps
`include "cbdp_cfg.svh"

// two-entry valid/ready buffer, flip-flop storage addressed by index
module cbdp_buf2
    import cbdp_pkg::*;
#(
    parameter int W = 8,
    parameter int DEPTH = `CBDP_BUF_DEPTH
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [W-1:0] mem_d [DEPTH];
    logic [AW-1:0] wr_idx_q, wr_idx_d, rd_idx_q, rd_idx_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    // honest full and empty from the entry count
    assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_idx_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // next pointers, count and storage
    always_comb begin
        mem_d = mem_q;
        wr_idx_d = wr_idx_q;
        rd_idx_d = rd_idx_q;
        if (push) begin
            mem_d[wr_idx_q] = in_data_i;
            wr_idx_d = (wr_idx_q == AW'(DEPTH-1)) ? '0 : wr_idx_q + 1'b1;
        end
        if (pop) begin
            rd_idx_d = (rd_idx_q == AW'(DEPTH-1)) ? '0 : rd_idx_q + 1'b1;
        end
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    // register state
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wr_idx_q <= '0;
            rd_idx_q <= '0;
            cnt_q <= '0;
        end else begin
            mem_q <= mem_d;
            wr_idx_q <= wr_idx_d;
            rd_idx_q <= rd_idx_d;
            cnt_q <= cnt_d;
        end
    end
endmodule // cbdp_buf2

module cbdp_cpu_end
    import cbdp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // bus pins
    cbdp_if.cpu_mp bus,
    // cycle requests from the core
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic req_write_i,
    input wire logic req_data_code_i,
    input wire logic req_excl_line_i,
    input wire cbdp_data_t req_wdata_i,
    // read data toward the core
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    output cbdp_data_t rd_data_o,
    output logic rd_perr_o,
    // inquire lookup
    output logic inq_lookup_o,
    input wire logic inq_hit_i,
    // status
    output logic role_dual_o,
    output logic wb_hold_o
);
    cbdp_state_t state_q, state_d;
    logic wr_q, wr_d, dc_q, dc_d;
    cbdp_data_t wdata_q, wdata_d;
    logic hold_q, hold_d;
    logic strap_s1_q, strap_s2_q;
    logic role_q, role_d;
    logic inq_seen_q, inq_seen_d;
    logic hit_n_q, hit_n_d;
    logic blocked, take, rd_push, buf_in_ready;
    logic [`CBDP_DATA_W:0] buf_in, buf_out;

    // strap is a pin: two flip-flops before any use
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            strap_s1_q <= 1'b0;
            strap_s2_q <= 1'b0;
        end else begin
            strap_s1_q <= bus.processor_role_strap;
            strap_s2_q <= strap_s1_q;
        end
    end

    // role follows the strap only while the bus reset is held
    assign role_d = bus.cpu_reset ? strap_s2_q : role_q;
    assign role_dual_o = role_q;

    // exclusive writes wait while the held flag stands
    assign blocked = req_write_i && req_excl_line_i && hold_q;
    assign req_ready_o = (state_q == CBDP_IDLE) && !bus.cpu_reset &&
                         !blocked && (req_write_i || buf_in_ready);
    assign take = req_valid_i && req_ready_o;
    assign rd_push = (state_q == CBDP_DATA) && !wr_q &&
                     !bus.burst_ready_ack_n;

    // bus cycle sequencer: address state then single data state
    always_comb begin
        state_d = state_q;
        wr_d = wr_q;
        dc_d = dc_q;
        wdata_d = wdata_q;
        unique case (state_q)
            CBDP_IDLE: begin
                if (take) begin
                    state_d = CBDP_ADDR;
                    wr_d = req_write_i;
                    dc_d = req_data_code_i;
                    wdata_d = req_wdata_i;
                end
            end
            CBDP_ADDR: begin
                state_d = CBDP_DATA;
            end
            CBDP_DATA: begin
                if (!bus.burst_ready_ack_n) begin
                    state_d = CBDP_IDLE;
                end
            end
        endcase
        if (bus.cpu_reset) begin
            state_d = CBDP_IDLE;
        end
    end

    // write throttle: set on a write with busy buffer, clear when empty
    always_comb begin
        hold_d = hold_q;
        if (!bus.ext_write_buffer_empty_n) begin
            hold_d = 1'b0;
        end
        if (state_q == CBDP_ADDR && wr_q && bus.ext_write_buffer_empty_n) begin
            hold_d = 1'b1; // set wins over clear
        end
    end
    assign wb_hold_o = hold_q;

    // inquire hit: strobe seen, lookup next clock, pin valid after that
    always_comb begin
        inq_seen_d = !bus.inquire_address_strobe_n;
        hit_n_d = hit_n_q;
        if (inq_seen_q) begin
            hit_n_d = !inq_hit_i; // held until next inquire
        end
    end
    assign inq_lookup_o = inq_seen_q;
    assign bus.inquire_hit_n = hit_n_q;

    // register cycle, throttle, role and inquire state
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= CBDP_IDLE;
            wr_q <= 1'b0;
            dc_q <= 1'b0;
            wdata_q <= '0;
            hold_q <= 1'b0;
            role_q <= 1'b0;
            inq_seen_q <= 1'b0;
            hit_n_q <= `CBDP_NEG;
        end else begin
            state_q <= state_d;
            wr_q <= wr_d;
            dc_q <= dc_d;
            wdata_q <= wdata_d;
            hold_q <= hold_d;
            role_q <= role_d;
            inq_seen_q <= inq_seen_d;
            hit_n_q <= hit_n_d;
        end
    end

    // cycle definition pins, valid with the address strobe
    assign bus.address_strobe_out_n = (state_q != CBDP_ADDR);
    assign bus.data_code = dc_q;
    assign bus.bus_write = wr_q;

    // ownership: primary low while it runs a cycle, high otherwise
    assign bus.dual_primary_n_o = (state_q == CBDP_IDLE);
    assign bus.dual_primary_n_oe = !role_q; // primary only

    // write data and lane parity in the data state
    assign bus.data_cpu_oe = (state_q == CBDP_DATA) && wr_q;
    assign bus.data_cpu_o = wdata_q;
    assign bus.par_cpu_o = cbdp_even_par(wdata_q);

    // dual role pulls the dual enable low while the bus reset stands
    assign bus.dual_enable_line_n_o = 1'b0;
    assign bus.dual_enable_line_n_oe = bus.cpu_reset && role_q;

    // read word plus parity check result into the buffer
    assign buf_in = {(cbdp_even_par(bus.data_lines) !=
                      bus.byte_parity_lines), bus.data_lines};
    assign rd_data_o = buf_out[`CBDP_DATA_W-1:0];
    assign rd_perr_o = buf_out[`CBDP_DATA_W];

    cbdp_buf2 #(
        .W(`CBDP_DATA_W + 1),
        .DEPTH(`CBDP_BUF_DEPTH)
    ) u_rd_buf (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .in_valid_i(rd_push),
        .in_ready_o(buf_in_ready),
        .in_data_i(buf_in),
        .out_valid_o(rd_valid_o),
        .out_ready_i(rd_ready_i),
        .out_data_o(buf_out)
    );
endmodule // cbdp_cpu_end

// ==== hw/cbdp_sys_end.sv ====
// system end of the bus: answers cycles, returns read data with parity,
// drives reset, strap, inquire strobe and write buffer state
// assumes the cpu end shares sys_clk_i
`timescale 1ns/10ps
`include "cbdp_cfg.svh"

module cbdp_sys_end
    import cbdp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // bus pins
    cbdp_if.sys_mp bus,
    // board controls
    input wire logic cpu_reset_i,
    input wire logic role_dual_i,
    input wire logic wbuf_busy_i,
    input wire logic inq_req_i,
    // cycle report
    output logic cyc_start_o,
    output logic cyc_write_o,
    output logic cyc_data_o,
    output logic cyc_dual_o,
    // write data from the cpu
    output logic wr_valid_o,
    input wire logic wr_ready_i,
    output cbdp_data_t wr_data_o,
    // read data to the cpu
    output logic rd_ready_o,
    input wire logic rd_valid_i,
    input wire cbdp_data_t rd_data_i,
    // status
    output logic dual_present_o,
    output logic inq_hit_o
);
    logic busy_q, busy_d, wr_q, wr_d;
    logic start_q, start_d, cw_q, cw_d, cd_q, cd_d, dual_q, dual_d;
    logic rst_q, present_q, present_d, inq_q, dual_enable_line_q;
    logic ads;

    assign ads = !bus.address_strobe_out_n;

    // track the data state and report the cycle issued with the strobe
    always_comb begin
        busy_d = busy_q;
        wr_d = wr_q;
        start_d = ads;
        cw_d = cw_q;
        cd_d = cd_q;
        dual_d = dual_q;
        if (busy_q && !bus.burst_ready_ack_n) begin
            busy_d = 1'b0;
        end
        if (ads) begin
            busy_d = 1'b1;
            wr_d = bus.bus_write;
            cw_d = bus.bus_write;
            cd_d = bus.data_code;
            dual_d = bus.dual_primary_n;
        end
    end

    // dual enable as seen on the last clock of the bus reset; the cpu
    // releases the line the moment reset falls, so use the stored copy
    assign present_d = (rst_q && !cpu_reset_i) ?
                       dual_enable_line_q : present_q;

    // register cycle tracking and straps
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_q <= 1'b0;
            wr_q <= 1'b0;
            start_q <= 1'b0;
            cw_q <= 1'b0;
            cd_q <= 1'b0;
            dual_q <= 1'b0;
            rst_q <= 1'b1;
            present_q <= 1'b0;
            inq_q <= 1'b0;
            dual_enable_line_q <= 1'b0;
        end else begin
            busy_q <= busy_d;
            wr_q <= wr_d;
            start_q <= start_d;
            cw_q <= cw_d;
            cd_q <= cd_d;
            dual_q <= dual_d;
            rst_q <= cpu_reset_i;
            present_q <= present_d;
            inq_q <= inq_req_i;
            dual_enable_line_q <= !bus.dual_enable_line_n;
        end
    end

    // burst ready when the user takes write data or has read data
    assign wr_valid_o = busy_q && wr_q;
    assign wr_data_o = bus.data_lines;
    assign rd_ready_o = busy_q && !wr_q;
    assign bus.burst_ready_ack_n = !((wr_valid_o && wr_ready_i) ||
                                     (rd_ready_o && rd_valid_i));

    // read data with even parity in the same clock
    assign bus.data_sys_oe = rd_ready_o && rd_valid_i;
    assign bus.data_sys_o = rd_data_i;
    assign bus.par_sys_o = cbdp_even_par(rd_data_i);

    // straps, throttle and inquire strobe toward the cpu
    assign bus.cpu_reset = cpu_reset_i;
    assign bus.processor_role_strap = role_dual_i;
    assign bus.ext_write_buffer_empty_n = wbuf_busy_i;
    assign bus.inquire_address_strobe_n = !inq_q;

    // reports
    assign cyc_start_o = start_q;
    assign cyc_write_o = cw_q;
    assign cyc_data_o = cd_q;
    assign cyc_dual_o = dual_q;
    assign dual_present_o = present_q;
    assign inq_hit_o = !bus.inquire_hit_n;
endmodule // cbdp_sys_end

// ==== verif/cbdp_sva.sv ====
// checker for the pins between the cpu end and the system end
// assumes one clock; fed from the interface signals by the testbench
`timescale 1ns/10ps

module cbdp_sva
    import cbdp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // cycle definition
    input wire logic address_strobe_out_n,
    input wire logic bus_write,
    input wire logic data_code,
    input wire logic dual_primary_n_oe,
    input wire logic dual_primary_n,
    // data lanes
    input wire cbdp_data_t data_cpu_o,
    input wire logic data_cpu_oe,
    input wire cbdp_par_t par_cpu_o,
    input wire cbdp_data_t data_sys_o,
    input wire logic data_sys_oe,
    input wire cbdp_par_t par_sys_o,
    // handshakes and straps
    input wire logic burst_ready_ack_n,
    input wire logic cpu_reset,
    input wire logic processor_role_strap,
    input wire logic inquire_address_strobe_n,
    input wire logic dual_enable_line_n,
    input wire logic inquire_hit_n
);
    logic [7:0] cpu_odd;
    logic [7:0] sys_odd;

    // odd count per lane plus its parity bit
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            cpu_odd[i] = ^{data_cpu_o[8*i +: 8], par_cpu_o[i]};
            sys_odd[i] = ^{data_sys_o[8*i +: 8], par_sys_o[i]};
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    strobe_one_clk_a: assert property (
        !address_strobe_out_n |=> address_strobe_out_n)
        else $error("address strobe longer than one clock");
    code_with_strobe_a: assert property (
        ($changed(data_code) || $changed(bus_write)) |-> !address_strobe_out_n)
        else $error("cycle type changed without strobe");
    primary_drives_a: assert property (
        (!cpu_reset && !processor_role_strap) |-> dual_primary_n_oe)
        else $error("primary left ownership line undriven");
    primary_busy_a: assert property (
        (!address_strobe_out_n && dual_primary_n_oe) |-> !dual_primary_n)
        else $error("ownership line high with strobe");
    wdata_phase_a: assert property (
        (!address_strobe_out_n && bus_write) |=> data_cpu_oe)
        else $error("write data missing after strobe");
    wdata_only_a: assert property (
        data_cpu_oe |-> (bus_write && address_strobe_out_n && !data_sys_oe))
        else $error("cpu drives data outside write data phase");
    cpu_par_a: assert property (
        data_cpu_oe |-> (cpu_odd == 8'h00))
        else $error("write parity not even");
    sys_par_a: assert property (
        data_sys_oe |-> (sys_odd == 8'h00))
        else $error("read parity not even");
    burst_ready_ack_data_a: assert property (
        !burst_ready_ack_n |-> (data_cpu_oe || data_sys_oe))
        else $error("burst ready without data");
    hit_two_clk_a: assert property (
        $changed(inquire_hit_n) |-> !$past(inquire_address_strobe_n, 2))
        else $error("hit changed off the inquire slot");
    dual_enable_line_reset_a: assert property (
        !dual_enable_line_n |-> (cpu_reset || $past(cpu_reset)))
        else $error("dual enable low outside reset");
    dual_enable_line_drive_a: assert property (
        (cpu_reset && processor_role_strap) [*6] |-> !dual_enable_line_n)
        else $error("dual role left dual enable high");

    // main scenarios
    write_c: cover property (!burst_ready_ack_n && data_cpu_oe);
    read_c: cover property (!burst_ready_ack_n && data_sys_oe);
    inquire_c: cover property (!inquire_address_strobe_n);
    dual_enable_line_c: cover property (!dual_enable_line_n);
endmodule // cbdp_sva

// ==== verif/cbdp_test.sv ====
// testbench joining the cpu end and the system end through the interface
// assumes the design files, package and interface are compiled first
`timescale 1ns/10ps

module cbdp_test
    import cbdp_pkg::*;
;
    logic sys_clk_i, nrst_i, cpu_reset_i, role_dual_i, wbuf_busy_i;
    logic inq_req_i, wr_ready_i, rd_valid_i, req_valid_i, req_write_i;
    logic req_data_code_i, req_excl_line_i, rd_ready_i, inq_hit_i;
    logic req_ready_o, rd_valid_o, rd_perr_o, role_dual_o, wb_hold_o;
    logic cyc_write_o, cyc_data_o, cyc_dual_o, wr_valid_o;
    logic rd_ready_o, dual_present_o, inq_hit_o, cyc_start_o, inq_lookup_o;
    cbdp_data_t rd_data_i, req_wdata_i, rd_data_o, wr_data_o;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;

    cbdp_if bus_if ();

    cbdp_cpu_end cbdp_cpu_end_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .bus(bus_if.cpu_mp), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .req_write_i(req_write_i),
        .req_data_code_i(req_data_code_i),
        .req_excl_line_i(req_excl_line_i), .req_wdata_i(req_wdata_i),
        .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i),
        .rd_data_o(rd_data_o), .rd_perr_o(rd_perr_o),
        .inq_lookup_o(inq_lookup_o),
        .inq_hit_i(inq_hit_i), .role_dual_o(role_dual_o),
        .wb_hold_o(wb_hold_o));

    cbdp_sys_end cbdp_sys_end_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .bus(bus_if.sys_mp), .cpu_reset_i(cpu_reset_i),
        .role_dual_i(role_dual_i), .wbuf_busy_i(wbuf_busy_i),
        .inq_req_i(inq_req_i), .cyc_start_o(cyc_start_o),
        .cyc_write_o(cyc_write_o),
        .cyc_data_o(cyc_data_o), .cyc_dual_o(cyc_dual_o),
        .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i),
        .wr_data_o(wr_data_o), .rd_ready_o(rd_ready_o),
        .rd_valid_i(rd_valid_i), .rd_data_i(rd_data_i),
        .dual_present_o(dual_present_o), .inq_hit_o(inq_hit_o));

    cbdp_sva cbdp_sva_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .address_strobe_out_n(bus_if.address_strobe_out_n),
        .bus_write(bus_if.bus_write), .data_code(bus_if.data_code),
        .dual_primary_n_oe(bus_if.dual_primary_n_oe),
        .dual_primary_n(bus_if.dual_primary_n),
        .data_cpu_o(bus_if.data_cpu_o), .data_cpu_oe(bus_if.data_cpu_oe),
        .par_cpu_o(bus_if.par_cpu_o), .data_sys_o(bus_if.data_sys_o),
        .data_sys_oe(bus_if.data_sys_oe), .par_sys_o(bus_if.par_sys_o),
        .burst_ready_ack_n(bus_if.burst_ready_ack_n),
        .cpu_reset(bus_if.cpu_reset),
        .processor_role_strap(bus_if.processor_role_strap),
        .inquire_address_strobe_n(bus_if.inquire_address_strobe_n),
        .dual_enable_line_n(bus_if.dual_enable_line_n),
        .inquire_hit_n(bus_if.inquire_hit_n));

    // free-running bus clock
    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    task automatic complete_run();
        if (fails == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            complete_run();
        end
    end

    task automatic tick();
        @(posedge sys_clk_i);
        #1;
    endtask

    task automatic chk(input string nm, input logic [63:0] s, e);
        n_tests++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask

    // even parity per lane, worked out locally
    function automatic cbdp_par_t exp_par(input cbdp_data_t d);
        for (int i = 0; i < 8; i++) begin
            exp_par[i] = ^d[8*i +: 8];
        end
    endfunction

    task automatic boot(input logic dual);
        cpu_reset_i = 1'b1;
        role_dual_i = dual;
        repeat (8) tick();
        chk("role", role_dual_o, dual);
        chk("dual_enable_line", bus_if.dual_enable_line_n, !dual);
        cpu_reset_i = 1'b0;
        tick();
        tick();
        chk("dpres", dual_present_o, dual);
    endtask

    task automatic do_write(input cbdp_data_t d, input logic cd, ex);
        req_valid_i = 1'b1;
        req_write_i = 1'b1;
        req_wdata_i = d;
        req_data_code_i = cd;
        req_excl_line_i = ex;
        while (req_ready_o !== 1'b1) tick();
        tick();
        req_valid_i = 1'b0;
        while (wr_valid_o !== 1'b1) tick();
        chk("wdata", wr_data_o, d);
        chk("wpar", bus_if.byte_parity_lines, exp_par(d));
        chk("dc", cyc_data_o, cd);
        chk("wr", cyc_write_o, 1'b1);
        chk("start", cyc_start_o, 1'b1);
        tick();
    endtask

    // read with a slow system answer of st cycles
    task automatic do_read(input cbdp_data_t d, input int st);
        req_valid_i = 1'b1;
        req_write_i = 1'b0;
        rd_data_i = ~d;
        while (req_ready_o !== 1'b1) tick();
        tick();
        req_valid_i = 1'b0;
        while (rd_ready_o !== 1'b1) tick();
        repeat (st) tick();
        rd_valid_i = 1'b1;
        rd_data_i = d;
        tick();
        rd_valid_i = 1'b0;
        rd_data_i = ~d;
    endtask

    task automatic pop(input cbdp_data_t d);
        rd_ready_i = 1'b1;
        while (rd_valid_o !== 1'b1) tick();
        chk("rdata", rd_data_o, d);
        chk("perr", rd_perr_o, 1'b0);
        tick();
    endtask

    task automatic inquire(input logic hit);
        inq_hit_i = hit;
        inq_req_i = 1'b1; // address assumed valid with the strobe
        tick();
        inq_req_i = 1'b0;
        tick();
        chk("lookup", inq_lookup_o, 1'b1);
        chk("hit_old", bus_if.inquire_hit_n, hit);
        tick();
        chk("hit_new", bus_if.inquire_hit_n, !hit);
        chk("hit_sys", inq_hit_o, hit);
    endtask

    // main sequence
    initial begin
        {nrst_i, wbuf_busy_i, inq_req_i, rd_valid_i, req_valid_i} = '0;
        {req_write_i, req_data_code_i, req_excl_line_i, rd_ready_i} = '0;
        {cpu_reset_i, role_dual_i, wr_ready_i, inq_hit_i} = 4'h7;
        rd_data_i = '0;
        req_wdata_i = '0;
        repeat (4) @(posedge sys_clk_i);
        #1;
        nrst_i = 1'b1;
        boot(1'b1);
        do_write(64'h0123_4567_89ab_cdef, 1'b1, 1'b0);
        chk("dual", cyc_dual_o, 1'b1);
        nrst_i = 1'b0;
        cpu_reset_i = 1'b1;
        tick();
        tick();
        nrst_i = 1'b1;
        boot(1'b0);
        chk("dp_idle", bus_if.dual_primary_n, 1'b1);
        for (int k = 0; k < 8; k++) begin
            do_write(64'h0000_0000_0000_0001 << (8 * k), k[0], 1'b0);
        end
        chk("prim", cyc_dual_o, 1'b0);
        do_write('1, 1'b0, 1'b0);
        do_read(64'hdead_beef_0bad_f00d, 0);
        do_read(64'h55aa_55aa_1234_8001, 3);
        chk("rd_type", cyc_write_o, 1'b0);
        tick();
        tick();
        chk("full", req_ready_o, 1'b0);
        pop(64'hdead_beef_0bad_f00d);
        pop(64'h55aa_55aa_1234_8001);
        chk("empty", rd_valid_o, 1'b0);
        wbuf_busy_i = 1'b1;
        do_write(64'h0000_ffff_0000_ffff, 1'b1, 1'b1);
        chk("hold", wb_hold_o, 1'b1);
        {req_write_i, req_excl_line_i} = 2'h3;
        tick();
        tick();
        chk("held", req_ready_o, 1'b0);
        req_excl_line_i = 1'b0;
        tick();
        chk("plain", req_ready_o, 1'b1);
        wbuf_busy_i = 1'b0;
        tick();
        tick();
        chk("release", wb_hold_o, 1'b0);
        do_write(64'h8000_0000_0000_0081, 1'b1, 1'b1);
        inquire(1'b1);
        inquire(1'b0);
        complete_run();
    end
endmodule // cbdp_test
